// file: core/cache_processor_port_init.sv
// Operation
// R1 - power returns: sweep clears every valid bit
// R2 - processor raises timing init on power/console reset
// R3 - timing init resets all timing-state flops
// R4 - processor raises register init on power/start
// R5 - register init clears internal registers
// R6 - everything runs on the free-running clock
// R7 - buffered T2/T3 time sync and delayed strobes
// R8 - processor drives six low address bits unchanged
// R9 - bit 00 picks byte for byte writes
// R10 - bit 01 picks word in block
// R11 - bits 05..02 form low index part
// R12 - bits 09..06 form high index part
// R13 - hit needs tag match, valid, good parity
// R14 - init and power inputs sampled as levels
`timescale 1ns/100ps
module cache_processor_port_init
(
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  // power and init levels
  input  wire logic                       acPowerFailing,
  input  wire logic                       dcOutOfRegulation,
  input  wire logic                       timingStateInit,
  input  wire logic                       cacheRegisterInit,
  // time states
  input  wire logic                       timeStateTwoBuffered,
  input  wire logic                       timeStateThreeBuffered,
  // physical address halves and byte-write flag
  input  wire logic [cpi_pkg::LOW_W-1:0]  physAddrLowSix,
  input  wire logic [cpi_pkg::HIGH_W-1:0] physAddrHighSixteen,
  input  wire logic                       byteWriteOp,
  // tag fill after a miss
  input  wire logic                       tagWriteEn,
  input  wire logic                       tagWriteWay,
  // address fields
  output logic                            byteSelect,
  output logic                            byteWriteSelect,
  output logic                            wordSelect,
  output logic [cpi_pkg::IDX_W-1:0]       cacheIndex,
  output logic [cpi_pkg::TAG_W-1:0]       addrTag,
  // lookup result and sweep busy flag
  output logic                            hit,
  output logic                            hitWay,
  output logic                            initBusy,
  // timing strobes
  output logic                            memorySyncStrobe,
  output logic                            delayedStateTwoStrobe
);
  import cpi_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rstMeta;  // first stage, read only by rstSync
  logic rstSync;  // released reset for the whole block

  // two flops so release lands cleanly on the clock
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ---------------------------------------------------------------
  // input sampling
  // ---------------------------------------------------------------
  logic acQ;     // sampled ac failing
  logic dcQ;     // sampled dc low
  logic tInitQ;  // sampled timing init
  logic rInitQ;  // sampled register init
  logic t2Q;     // sampled T2
  logic t3Q;     // sampled T3

  // same-clock levels, one register stage each
  always_ff @(posedge ref_clk or negedge rstSync)  // see R6
  begin
    if (!rstSync)
    begin
      acQ    <= 1'b1;  // assume power bad until seen good
      dcQ    <= 1'b1;
      tInitQ <= 1'b0;
      rInitQ <= 1'b0;
      t2Q    <= 1'b0;
      t3Q    <= 1'b0;
    end
    else
    begin
      acQ    <= acPowerFailing;     // see R14
      dcQ    <= dcOutOfRegulation;  // see R14
      tInitQ <= timingStateInit;    // see R14
      rInitQ <= cacheRegisterInit;  // see R14
      t2Q    <= timeStateTwoBuffered;
      t3Q    <= timeStateThreeBuffered;
    end
  end

  // ---------------------------------------------------------------
  // address split
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] inAddr;   // joined halves, used unchanged  see R8
  logic [IDX_W-1:0]  inIndex;  // combined index
  logic [TAG_W-1:0]  inTag;    // compare field

  assign inAddr  = {physAddrHighSixteen, physAddrLowSix};
  assign inIndex = inAddr[IDX_MSB:IDX_LSB];  // see R11 see R12
  assign inTag   = inAddr[TAG_MSB:TAG_LSB];

  // tag parity over the stored field and its valid bit
  function automatic logic tagParity(input logic [TAG_W-1:0] t, input logic v);
    return ^{t, v};
  endfunction

  // ---------------------------------------------------------------
  // power-up sweep and tag store
  // ---------------------------------------------------------------
  cpi_init_e          state;            // sweep state
  cpi_init_e          next_state;
  logic [IDX_W-1:0]   clearIdx;         // sweep position
  logic [IDX_W-1:0]   next_clearIdx;
  logic [NUM_SETS-1:0] validWay      [NUM_WAYS];  // valid bits per group
  logic [NUM_SETS-1:0] next_validWay [NUM_WAYS];
  logic [TAG_W:0]     tagMem [NUM_WAYS][NUM_SETS];  // parity on top, no reset
  logic               powerOk;          // both power flags negated
  logic               fillOk;           // fill allowed this cycle

  assign powerOk = !acQ && !dcQ;
  assign fillOk  = tagWriteEn && (state == CPI_RUN);

  // sweep walks one index per cycle; a new power dip restarts it
  always_comb
  begin
    next_state    = state;
    next_clearIdx = clearIdx;
    next_validWay = validWay;
    case (state)
      CPI_WAIT_PWR:
        if (powerOk)
        begin
          next_state    = CPI_CLEAR;  // see R1
          next_clearIdx = IDX_ZERO;
        end
      CPI_CLEAR:
        if (!powerOk)
          next_state = CPI_WAIT_PWR;
        else
        begin
          for (int w = 0; w < NUM_WAYS; w++)
            next_validWay[w][clearIdx] = 1'b0;  // see R1
          next_clearIdx = clearIdx + IDX_ONE;
          if (clearIdx == IDX_LAST)
            next_state = CPI_RUN;
        end
      default:
        if (!powerOk)
          next_state = CPI_WAIT_PWR;
    endcase
    // fill marks the latched index valid in the chosen group
    if (fillOk)
      next_validWay[tagWriteWay][cacheIndex] = 1'b1;
  end

  // register sweep state and valid bits
  always_ff @(posedge ref_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      state    <= CPI_WAIT_PWR;
      clearIdx <= IDX_ZERO;
      for (int w = 0; w < NUM_WAYS; w++)
        validWay[w] <= VALID_NONE;
    end
    else
    begin
      state    <= next_state;
      clearIdx <= next_clearIdx;
      validWay <= next_validWay;
    end
  end

  // tag array, no reset: valid bits make stale tags harmless
  always_ff @(posedge ref_clk)
  begin
    if (fillOk)
      tagMem[tagWriteWay][cacheIndex] <= {tagParity(addrTag, 1'b1), addrTag};
  end

  // ---------------------------------------------------------------
  // lookup
  // ---------------------------------------------------------------
  logic [NUM_WAYS-1:0] wayMatch;  // per-group hit term

  // compare both groups at the incoming index
  for (genvar g = 0; g < NUM_WAYS; g++)
  begin : gMatch
    logic [TAG_W:0] entry;
    assign entry       = tagMem[g][inIndex];
    assign wayMatch[g] = validWay[g][inIndex]
                         && (entry[TAG_W-1:0] == inTag)
                         && (entry[TAG_W] == tagParity(inTag, 1'b1));  // see R13
  end

  // ---------------------------------------------------------------
  // address and result registers
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] addrLatch;       // held address
  logic [ADDR_W-1:0] next_addrLatch;
  logic              byteOpLatch;     // held byte-write flag
  logic              next_byteOpLatch;
  logic              next_hit;
  logic              next_hitWay;

  // register init wins over any new lookup
  always_comb
  begin
    next_addrLatch   = inAddr;
    next_byteOpLatch = byteWriteOp;
    next_hit         = |wayMatch && (state == CPI_RUN);  // see R13
    next_hitWay      = wayMatch[1];
    if (rInitQ)
    begin
      next_addrLatch   = ADDR_RESET;  // see R5
      next_byteOpLatch = 1'b0;
      next_hit         = 1'b0;
      next_hitWay      = 1'b0;
    end
  end

  // register address fields and result together
  always_ff @(posedge ref_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      addrLatch   <= ADDR_RESET;
      byteOpLatch <= 1'b0;
      hit         <= 1'b0;
      hitWay      <= 1'b0;
    end
    else
    begin
      addrLatch   <= next_addrLatch;
      byteOpLatch <= next_byteOpLatch;
      hit         <= next_hit;
      hitWay      <= next_hitWay;
    end
  end

  assign byteSelect      = addrLatch[BYTE_BIT];            // see R9
  assign byteWriteSelect = addrLatch[BYTE_BIT] && byteOpLatch;  // see R9
  assign wordSelect      = addrLatch[WORD_BIT];            // see R10
  assign cacheIndex      = addrLatch[IDX_MSB:IDX_LSB];     // see R11 see R12
  assign addrTag         = addrLatch[TAG_MSB:TAG_LSB];
  assign initBusy        = (state != CPI_RUN);

  // ---------------------------------------------------------------
  // timing-state strobes
  // ---------------------------------------------------------------
  logic next_memSync;  // sync window from T2 until T3
  logic next_t2Dly;    // T2 one clock late

  // timing init overrides the time states
  always_comb
  begin
    next_memSync = memorySyncStrobe;
    next_t2Dly   = t2Q;                  // see R7
    if (t2Q)
      next_memSync = 1'b1;               // see R7
    else if (t3Q)
      next_memSync = 1'b0;               // see R7
    if (tInitQ)
    begin
      next_memSync = 1'b0;               // see R3
      next_t2Dly   = 1'b0;               // see R3
    end
  end

  // register the strobes
  always_ff @(posedge ref_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      memorySyncStrobe      <= 1'b0;
      delayedStateTwoStrobe <= 1'b0;
    end
    else
    begin
      memorySyncStrobe      <= next_memSync;
      delayedStateTwoStrobe <= next_t2Dly;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cbChk @(posedge ref_clk); endclocking
  default disable iff (!rstSync);

  sequence s_lastSweep;
    state == CPI_CLEAR && clearIdx == IDX_LAST && powerOk;
  endsequence

  property p_sweep_start;
    state == CPI_WAIT_PWR && powerOk |=> state == CPI_CLEAR && clearIdx == IDX_ZERO;
  endproperty
  a_sweep_start: assert property (p_sweep_start)  // see R1
    else $error("sweep did not start after power returned");

  property p_sweep_done;
    s_lastSweep |=> state == CPI_RUN && validWay[0] == VALID_NONE
                    && validWay[1] == VALID_NONE;
  endproperty
  a_sweep_done: assert property (p_sweep_done)  // see R1
    else $error("valid bits left set after sweep");

  property p_timing_init;
    tInitQ |=> !memorySyncStrobe && !delayedStateTwoStrobe;
  endproperty
  a_timing_init: assert property (p_timing_init)  // see R3
    else $error("timing flops not reset by timing init");

  property p_reg_init;
    cacheRegisterInit |-> ##2 !hit && addrLatch == ADDR_RESET;
  endproperty
  a_reg_init: assert property (p_reg_init)  // see R5
    else $error("registers not cleared by register init");

  property p_t2_delay;
    timeStateTwoBuffered && !timingStateInit |-> ##2 delayedStateTwoStrobe && memorySyncStrobe;
  endproperty
  a_t2_delay: assert property (p_t2_delay)  // see R7
    else $error("delayed T2 or sync strobe missing");

  property p_t3_end;
    t3Q && !t2Q |=> !memorySyncStrobe;
  endproperty
  a_t3_end: assert property (p_t3_end)  // see R7
    else $error("sync strobe outlived T3");

  property p_fields;
    !rInitQ |=> cacheIndex == $past(inIndex) && wordSelect == $past(inAddr[WORD_BIT])
                           && byteSelect == $past(inAddr[BYTE_BIT]);
  endproperty
  a_fields: assert property (p_fields)  // see R9 see R10 see R11 see R12
    else $error("address fields wrong");

  property p_no_hit_busy;
    state != CPI_RUN |=> !hit;
  endproperty
  a_no_hit_busy: assert property (p_no_hit_busy)  // see R13
    else $error("hit reported while not running");

  property p_power_drop;
    acPowerFailing && state == CPI_RUN |-> ##2 state == CPI_WAIT_PWR;
  endproperty
  a_power_drop: assert property (p_power_drop)  // see R14
    else $error("power fail level not honoured");
endmodule

// file: core/cpi_pkg.sv
// ---------------------------------------------------------------
// processor port constants
// ---------------------------------------------------------------
package cpi_pkg;
  // address split
  localparam int ADDR_W    = 22;   // full physical address width
  localparam int LOW_W     = 6;    // low bits from the processor mux
  localparam int HIGH_W    = 16;   // high bits from memory management
  localparam int BYTE_BIT  = 0;    // byte within word
  localparam int WORD_BIT  = 1;    // word within two-word block
  localparam int IDX_LSB   = 2;    // index low end
  localparam int IDX_MSB   = 9;    // index high end
  localparam int IDX_W     = 8;    // index width
  localparam int TAG_LSB   = 10;   // tag low end
  localparam int TAG_MSB   = 21;   // tag high end
  localparam int TAG_W     = 12;   // tag width
  localparam int NUM_SETS  = 256;  // index positions
  localparam int NUM_WAYS  = 2;    // tag groups

  // reset and sweep values
  localparam logic [IDX_W-1:0]    IDX_ZERO   = 8'h00;
  localparam logic [IDX_W-1:0]    IDX_ONE    = 8'h01;
  localparam logic [IDX_W-1:0]    IDX_LAST   = 8'hFF;
  localparam logic [ADDR_W-1:0]   ADDR_RESET = 22'h000000;
  localparam logic [NUM_SETS-1:0] VALID_NONE = '0;

  // power-up sequencing
  typedef enum logic [1:0] {CPI_WAIT_PWR, CPI_CLEAR, CPI_RUN} cpi_init_e;
endpackage

// file: test/cpi_proc_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// processor side stand-in: power, init, time states, address
// ---------------------------------------------------------------
module cpi_proc_model
(
  // clock
  input  wire logic                        ref_clk,
  // requests from the bench
  input  wire logic                        powerBad,
  input  wire logic                        consoleReset,
  input  wire logic                        consoleStart,
  input  wire logic                        runCycle,
  input  wire logic [cpi_pkg::ADDR_W-1:0]  physAddr,
  // lines toward the cache
  output logic                     acPowerFailing,
  output logic                     dcOutOfRegulation,
  output logic                     timingStateInit,
  output logic                     cacheRegisterInit,
  output logic                     timeStateTwoBuffered,
  output logic                     timeStateThreeBuffered,
  output logic [cpi_pkg::LOW_W-1:0]        physAddrLowSix,
  output logic [cpi_pkg::HIGH_W-1:0]       physAddrHighSixteen
);
  import cpi_pkg::*;

  logic [1:0] phase = 2'h0;  // micro-cycle time state
  // one supply failure raises both warnings
  assign acPowerFailing    = powerBad;
  assign dcOutOfRegulation = powerBad;
  // init lines follow power loss and the console
  assign timingStateInit   = powerBad | consoleReset;
  assign cacheRegisterInit = powerBad | consoleStart;
  // low bits bypass mapping, high bits come from it
  assign physAddrLowSix      = physAddr[LOW_W-1:0];
  assign physAddrHighSixteen = physAddr[ADDR_W-1:LOW_W];
  // four-step micro-cycle, parked while halted; moves just after the edge
  always @(posedge ref_clk)
    phase <= #1 runCycle ? phase + 2'h1 : 2'h0;
  assign timeStateTwoBuffered   = (phase == 2'h1);
  assign timeStateThreeBuffered = (phase == 2'h2);
endmodule

// file: test/tb.sv
`timescale 1ns/100ps
module tb;
  import cpi_pkg::*;
  // ---------------------------------------------------------------
  // clock, reset, counters
  // ---------------------------------------------------------------
  logic              ref_clk = 1'b0;
  logic              rst_b   = 1'b0;
  int                n_errors = 0;
  int                samples_checked = 0;
  int                n;
  always #2.5 ref_clk = ~ref_clk;
  // model requests and direct cache inputs
  logic              powerBad = 1'b0, consoleReset = 1'b0, consoleStart = 1'b0;
  logic              runCycle = 1'b0, byteWriteOp = 1'b0;
  logic              tagWriteEn = 1'b0, tagWriteWay = 1'b0;
  logic [ADDR_W-1:0] physAddr = ADDR_RESET;
  // wires between model and cache
  logic              acF, dcF, tInit, rInit, t2, t3;
  logic [LOW_W-1:0]  lowSix;
  logic [HIGH_W-1:0] highSixteen;
  // cache outputs
  logic              byteSelect, byteWriteSelect, wordSelect, hit, hitWay, initBusy;
  logic              memorySyncStrobe, delayedStateTwoStrobe;
  logic [IDX_W-1:0]  cacheIndex;
  logic [TAG_W-1:0]  addrTag;
  cpi_proc_model u_proc (.ref_clk(ref_clk), .powerBad(powerBad), .consoleReset(consoleReset),
    .consoleStart(consoleStart), .runCycle(runCycle), .physAddr(physAddr),
    .acPowerFailing(acF), .dcOutOfRegulation(dcF), .timingStateInit(tInit),
    .cacheRegisterInit(rInit), .timeStateTwoBuffered(t2), .timeStateThreeBuffered(t3),
    .physAddrLowSix(lowSix), .physAddrHighSixteen(highSixteen));
  cache_processor_port_init dut (.ref_clk(ref_clk), .rst_b(rst_b), .acPowerFailing(acF),
    .dcOutOfRegulation(dcF), .timingStateInit(tInit), .cacheRegisterInit(rInit),
    .timeStateTwoBuffered(t2), .timeStateThreeBuffered(t3), .physAddrLowSix(lowSix),
    .physAddrHighSixteen(highSixteen), .byteWriteOp(byteWriteOp), .tagWriteEn(tagWriteEn),
    .tagWriteWay(tagWriteWay), .byteSelect(byteSelect), .byteWriteSelect(byteWriteSelect),
    .wordSelect(wordSelect), .cacheIndex(cacheIndex), .addrTag(addrTag), .hit(hit),
    .hitWay(hitWay), .initBusy(initBusy), .memorySyncStrobe(memorySyncStrobe),
    .delayedStateTwoStrobe(delayedStateTwoStrobe));
  // ---------------------------------------------------------------
  // shared checks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // present an address, let it be taken, compare the split fields
  task look(input logic [ADDR_W-1:0] a, input logic bw, input logic expHit);
    @(posedge ref_clk);
    #1 physAddr = a;
    byteWriteOp = bw;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(byteSelect, a[BYTE_BIT], "byte");
    chk(byteWriteSelect, a[BYTE_BIT] & bw, "byte write");
    chk(wordSelect, a[WORD_BIT], "word");
    chk(cacheIndex, a[IDX_MSB:IDX_LSB], "index");
    chk(addrTag, a[TAG_MSB:TAG_LSB], "tag");
    chk(hit, expHit, "hit");
  endtask
  // load one group with the held address, then look again
  task fill(input logic [ADDR_W-1:0] a, input logic way);
    look(a, 1'b0, 1'b0);
    @(posedge ref_clk);
    #1 tagWriteEn = 1'b1;
    tagWriteWay = way;
    @(posedge ref_clk);
    #1 tagWriteEn = 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({hit, hitWay}, {1'b1, way}, "fill hit");
  endtask
  // wait for the valid sweep, return its length in n
  task sweep_wait;
    for (n = 0; n < 600 && initBusy !== 1'b0; n++)
      @(negedge ref_clk);
    chk({n >= NUM_SETS, initBusy}, 2'b10, "sweep length");
  endtask
  // ---------------------------------------------------------------
  // time-state strobe reference, one sampling stage then the strobe flop
  // ---------------------------------------------------------------
  logic [1:0] t2h = 2'h0, tih = 2'h0;
  logic       t3h = 1'b0;
  logic       syncExp = 1'b0;
  logic       chkTime = 1'b0;
  always @(posedge ref_clk)
  begin
    t2h <= {t2h[0], t2};
    t3h <= t3;
    tih <= {tih[0], tInit};
    syncExp <= tih[0] ? 1'b0 : t2h[0] ? 1'b1 : t3h ? 1'b0 : syncExp;
  end
  always @(negedge ref_clk)
    if (chkTime)
    begin
      chk(delayedStateTwoStrobe, t2h[1] & ~tih[1], "delayed T2");
      chk(memorySyncStrobe, syncExp, "mem sync");
    end
  // ---------------------------------------------------------------
  // ordinary cases as rows: {byte write, address}
  // ---------------------------------------------------------------
  logic [ADDR_W:0] rows [8] = '{23'h000000, 23'h3FFFFF, 23'h6AAAAA, 23'h155555,
                                23'h400001, 23'h000002, 23'h0003FC, 23'h7FFC00};
  localparam logic [ADDR_W-1:0] ADDR_A = 22'h2ABCD4;
  localparam logic [ADDR_W-1:0] ADDR_B = 22'h15BCD4;  // same index, other tag
  localparam logic [ADDR_W-1:0] ADDR_C = 22'h0FFCD4;  // same index, third tag
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({initBusy, hit, cacheIndex}, {1'b1, 1'b0, IDX_ZERO}, "in reset");
    @(posedge ref_clk);
    #1 rst_b = 1'b1;
    sweep_wait();
    foreach (rows[i])
      look(rows[i][ADDR_W-1:0], rows[i][ADDR_W], 1'b0);
    // both groups at one index, then a third tag misses
    fill(ADDR_A, 1'b1);
    fill(ADDR_B, 1'b0);
    look(ADDR_A, 1'b0, 1'b1);
    look(ADDR_C, 1'b0, 1'b0);
    // register init mid-stream clears the latched fields
    @(posedge ref_clk);
    #1 physAddr = ADDR_A;
    consoleStart = 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({hit, cacheIndex, addrTag}, '0, "register init");
    @(posedge ref_clk);
    #1 consoleStart = 1'b0;
    look(ADDR_A, 1'b0, 1'b1);
    // time states running, console reset in the middle
    @(posedge ref_clk);
    #1 chkTime = 1'b1;
    runCycle = 1'b1;
    repeat (21) @(posedge ref_clk);
    #1 consoleReset = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 consoleReset = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1 runCycle = 1'b0;
    repeat (4) @(posedge ref_clk);
    chkTime = 1'b0;
    // power dip restarts the sweep and forgets every tag
    #1 powerBad = 1'b1;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(initBusy, 1'b1, "busy on power loss");
    @(posedge ref_clk);
    #1 powerBad = 1'b0;
    sweep_wait();
    look(ADDR_A, 1'b0, 1'b0);
    look(ADDR_B, 1'b0, 1'b0);
    wrap_up();
  end
  // hang guard, sized well past the expected run
  initial
  begin
    #30000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end
  // ---------------------------------------------------------------
  // verdict
  // ---------------------------------------------------------------
  task wrap_up;
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
endmodule
